// ==== shared/ubm_pkg.sv ====
package ubm_pkg;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h00;
  localparam logic [7:0] ADDR_LOW_OFS = 8'h04;
  localparam logic [7:0] MASK_HIGH_OFS = 8'h08;
  localparam logic [7:0] MASK_LOW_OFS = 8'h0c;
  localparam logic [7:0] CYCLE_SEL_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] CLEAR_OFS = 8'h18;
  localparam logic [7:0] ENABLE_OFS = 8'h1c;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [7:0] CYCLE_SEL_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int MASTER_HI_POS = 7;
  localparam int MASTER_LO_POS = 6;
  localparam int FETCH_DATA_HI_POS = 5;
  localparam int FETCH_DATA_LO_POS = 4;
  localparam int DIR_HI_POS = 3;
  localparam int DIR_LO_POS = 2;
  localparam int SIZE_HI_POS = 1;
  localparam int SIZE_LO_POS = 0;
  localparam int ST_MATCH_POS = 0;
  localparam int ST_LOST_POS = 1;
  localparam logic [1:0] SIZE_ANY = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;
  localparam logic [3:0] BREAK_LEVEL = 4'hf;
  localparam logic [3:0] ACCEPT_MAX_MASK = 4'he;

  typedef struct packed {
    logic valid;
    logic periph;
    logic fetch;
    logic write;
    logic [1:0] size;
    logic dual;
    logic overrun;
    logic branch_target;
    logic no_delay;
    logic [31:0] addr;
  } ubm_cyc_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } ubm_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_AERR = 3'b010,
    ST_PEND = 3'b100
  } ubm_state_t;
endpackage

// ==== verilog/ubm_user_break.sv ====
`timescale 1ns/1ps
// Contract
// - Ordinary fetches are even, so an odd fetch condition never matches.
// - Odd first fetch after branch: address error first, then user break.
// - Data write of selected size at exact address raises break request.
// - Word data condition on odd address never matches; data accesses are aligned.
// - Peripheral transfer cycles are matched like processor cycles.
// - Peripheral cycles never match an instruction fetch condition.
// - Break latched at the dual fetch survives a later condition rewrite.
// - Non-delayed taken branch: two overrun fetches precede destination.
// - Delayed taken branch: delay slot, one overrun, then destination.
// - Discarded overrun fetches never match a fetch break.
// - With data selected too, an overrun fetch counts as data match.
// - Higher-priority exception in decode may drop the pending break.
// - No break on an even first destination fetch of a non-delayed branch.
// - Any of master, fetch/data, direction fields zero: never break.
// - Fields: 01 first, 10 second, 11 both; size 01/10/11, 00 ignored.
// - Request carries level 15, accepted only at mask 14 or below.
module ubm_user_break
  import ubm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire ubm_req_t req_i,
  output logic [31:0] rdata_o,
  input wire ubm_cyc_t cyc_i,
  input wire logic aerr_done_i,
  input wire logic hi_exc_i,
  input wire logic [3:0] mask_level_i,
  input wire logic brk_ack_i,
  output logic brk_req_o,
  output logic brk_take_o,
  output logic [3:0] brk_level_o,
  output logic irq_o
);
  logic [15:0] bar_hi_r;
  logic [15:0] bar_lo_r;
  logic [15:0] bam_hi_r;
  logic [15:0] bam_lo_r;
  logic [7:0] sel_r;
  logic [1:0] status_r;
  logic [1:0] enable_r;
  ubm_state_t state_r;
  logic [31:0] bar;
  logic [31:0] bam;
  logic match;
  logic fetch_hit;
  logic data_hit;
  logic odd_target;
  logic lost;
  logic [1:0] st_set;
  logic [1:0] st_clr;

  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [31:0] ref_a,
                                    input logic [31:0] msk);
    addr_hit = ((a ^ ref_a) & ~msk) == 32'h0000_0000;
  endfunction

  function automatic logic aligned(input logic [1:0] sz,
                                   input logic [31:0] a);
    case (sz)
      SIZE_WORD: aligned = ~a[0];
      SIZE_LONG: aligned = a[1:0] == 2'h0;
      default: aligned = 1'b1;
    endcase
  endfunction

  assign bar = {bar_hi_r, bar_lo_r};
  assign bam = {bam_hi_r, bam_lo_r};

  always_comb begin
    logic sel_ok;
    logic master_ok;
    logic dir_ok;
    logic [1:0] szc;
    logic [31:0] second;
    sel_ok = 1'b0;
    master_ok = 1'b0;
    dir_ok = 1'b0;
    szc = sel_r[SIZE_HI_POS:SIZE_LO_POS];
    second = cyc_i.addr + 32'h0000_0002;
    sel_ok = (sel_r[MASTER_HI_POS:MASTER_LO_POS] != 2'h0) &&
             (sel_r[FETCH_DATA_HI_POS:FETCH_DATA_LO_POS] != 2'h0) &&
             (sel_r[DIR_HI_POS:DIR_LO_POS] != 2'h0);
    master_ok = cyc_i.periph ? sel_r[MASTER_HI_POS] : sel_r[MASTER_LO_POS];
    dir_ok = cyc_i.write ? sel_r[DIR_HI_POS] : sel_r[DIR_LO_POS];
    odd_target = cyc_i.branch_target && cyc_i.addr[0];
    // Fetches count as word size; a dual fetch carries two starts
    fetch_hit = cyc_i.fetch && !cyc_i.periph &&
                sel_r[FETCH_DATA_LO_POS] &&
                !cyc_i.overrun &&
                !(cyc_i.branch_target && cyc_i.no_delay &&
                  !cyc_i.addr[0]) &&
                (szc == SIZE_ANY || szc == SIZE_WORD) &&
                (!cyc_i.addr[0] || odd_target) &&
                (addr_hit(cyc_i.addr, bar, bam) ||
                 (cyc_i.dual && addr_hit(second, bar, bam)));
    data_hit = sel_r[FETCH_DATA_HI_POS] &&
               ((!cyc_i.fetch && (szc == SIZE_ANY || szc == cyc_i.size) &&
                 aligned(cyc_i.size, cyc_i.addr) &&
                 addr_hit(cyc_i.addr, bar, bam)) ||
                (cyc_i.fetch && cyc_i.overrun &&
                 addr_hit(cyc_i.addr, bar, bam)));
    match = cyc_i.valid && sel_ok && master_ok && dir_ok &&
            (fetch_hit || data_hit);
  end

  // Only one break is held; further matches are ignored until the first resolves
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (match && fetch_hit && odd_target) begin
            state_r <= ST_AERR;
          end else if (match) begin
            state_r <= ST_PEND;
          end
        end
        ST_AERR: begin
          if (aerr_done_i) begin
            state_r <= ST_PEND;
          end
        end
        ST_PEND: begin
          if (brk_ack_i || hi_exc_i) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign lost = (state_r == ST_PEND) && hi_exc_i && !brk_ack_i;
  assign brk_req_o = state_r == ST_PEND;
  // Masked level 15 keeps the request pending rather than dropping it
  assign brk_take_o = brk_req_o && (mask_level_i <= ACCEPT_MAX_MASK);
  assign brk_level_o = BREAK_LEVEL;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bar_hi_r <= HALF_RST;
      bar_lo_r <= HALF_RST;
      bam_hi_r <= HALF_RST;
      bam_lo_r <= HALF_RST;
      sel_r <= CYCLE_SEL_RST;
    end else if (req_i.we) begin
      case (req_i.addr)
        ADDR_HIGH_OFS: bar_hi_r <= req_i.wdata[15:0];
        ADDR_LOW_OFS: bar_lo_r <= req_i.wdata[15:0];
        MASK_HIGH_OFS: bam_hi_r <= req_i.wdata[15:0];
        MASK_LOW_OFS: bam_lo_r <= req_i.wdata[15:0];
        CYCLE_SEL_OFS: sel_r <= req_i.wdata[7:0];
        default: ;
      endcase
    end
  end

  assign st_set = {lost, match && (state_r == ST_IDLE)};
  assign st_clr = (req_i.we && req_i.addr == CLEAR_OFS) ?
                  req_i.wdata[1:0] : 2'h0;

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_r <= IRQ_RST;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_r <= IRQ_RST;
    end else if (req_i.we && req_i.addr == ENABLE_OFS) begin
      enable_r <= req_i.wdata[1:0];
    end
  end

  assign irq_o = |(status_r & enable_r);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (req_i.re) begin
      case (req_i.addr)
        ADDR_HIGH_OFS: rdata_o <= {16'h0000, bar_hi_r};
        ADDR_LOW_OFS: rdata_o <= {16'h0000, bar_lo_r};
        MASK_HIGH_OFS: rdata_o <= {16'h0000, bam_hi_r};
        MASK_LOW_OFS: rdata_o <= {16'h0000, bam_lo_r};
        CYCLE_SEL_OFS: rdata_o <= {24'h000000, sel_r};
        STATUS_OFS: rdata_o <= {30'h0000_0000, status_r};
        ENABLE_OFS: rdata_o <= {30'h0000_0000, enable_r};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule

// ==== testbench/ubm_user_break_props.sv ====
`timescale 1ns/1ps
module ubm_user_break_props
  import ubm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire ubm_req_t req_i,
  input wire logic [31:0] rdata_o,
  input wire ubm_cyc_t cyc_i,
  input wire logic aerr_done_i,
  input wire logic hi_exc_i,
  input wire logic [3:0] mask_level_i,
  input wire logic brk_ack_i,
  input wire logic brk_req_o,
  input wire logic brk_take_o,
  input wire logic [3:0] brk_level_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic fq = cyc_i.valid && cyc_i.fetch && !cyc_i.overrun
    && !aerr_done_i;
  break_level_a: assert property (brk_level_o == BREAK_LEVEL)
    else $error("level");
  take_gate_a: assert property (brk_take_o ==
    (brk_req_o && mask_level_i <= ACCEPT_MAX_MASK)) else $error("take");
  rdata_idle_a: assert property (!$past(req_i.re) |-> !rdata_o)
    else $error("rdata");
  req_hold_a: assert property (brk_req_o && !brk_ack_i
    && !hi_exc_i |=> brk_req_o) else $error("hold");
  req_drop_a: assert property (brk_req_o
    && (brk_ack_i || hi_exc_i) |=> !brk_req_o) else $error("drop");
  odd_fetch_a: assert property (fq && cyc_i.addr[0]
    && !cyc_i.branch_target |=> !$rose(brk_req_o)) else $error("odd");
  periph_fetch_a: assert property (fq && cyc_i.periph
    |=> !$rose(brk_req_o)) else $error("periph");
  dest_fetch_a: assert property (fq && cyc_i.no_delay
    && cyc_i.branch_target |=> !$rose(brk_req_o)) else $error("dest");
  cover property (brk_req_o && !brk_take_o);
  cover property (brk_req_o && brk_ack_i);
  cover property (brk_req_o && aerr_done_i);
endmodule

bind ubm_user_break ubm_user_break_props u_props (.*);

// ==== testbench/ubm_interrupt_controller_model.sv ====
`timescale 1ns/1ps
module ubm_interrupt_controller_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic take_i,
  input wire logic [1:0] dly_i,
  output logic ack_o
);
  logic [1:0] cnt_r;
  // Delay gives prompt and slow answers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 2'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= take_i && !ack_o && cnt_r == dly_i;
      cnt_r <= take_i && !ack_o ? cnt_r + 2'h1 : 2'h0;
    end
  end
endmodule

// ==== testbench/test_user_break_condition_matcher.sv ====
`timescale 1ns/1ps
module test_user_break_condition_matcher;
  import ubm_pkg::*;
  logic clk_i = 0, rstn_i = 0, aerr_done_i = 0, hi_exc_i = 0;
  logic brk_ack_i, brk_req_o, brk_take_o, irq_o;
  logic [3:0] mask_level_i = 0, brk_level_o;
  logic [1:0] dly = 0;
  logic [31:0] rdata_o, a;
  integer seed = 32'hcc74, num_errors = 0, comparisons = 0;
  ubm_req_t req_i = '0;
  ubm_cyc_t cyc_i = '0;
  always #2 clk_i = ~clk_i;
  ubm_user_break u_ubm_user_break (.*);
  ubm_interrupt_controller_model u_ubm_interrupt_controller_model (.*, .take_i(brk_take_o), .dly_i(dly),
    .ack_o(brk_ack_i));
  task automatic final_report;
    $display("%0d bad of %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Read checks data against d; never both strobes
  task automatic acc(input logic [7:0] ad, input logic [31:0] d, bit w);
    req_i <= '{ad, d, w, !w};
    @(posedge clk_i) req_i <= '0;
    #1 if (!w) chk("rdata", d, rdata_o);
    @(posedge clk_i);
  endtask
  task automatic go(input logic [31:0] b, input logic [7:0] s,
      input logic [4:0] k, input logic [3:0] f, x, input logic e);
    acc(ADDR_HIGH_OFS, {16'h0, b[31:16]}, 1);
    acc(ADDR_LOW_OFS, {16'h0, b[15:0]}, 1);
    acc(CYCLE_SEL_OFS, {24'h0, s}, 1);
    cyc_i <= {1'b1, k, f, b ^ {28'h0, x}};
    @(posedge clk_i) cyc_i <= '0;
    #1 chk("brk", 32'(e), 32'(brk_req_o));
    chk("take", 32'(e && mask_level_i < 4'hf), 32'(brk_take_o));
    chk("irq", 32'(e), 32'(irq_o));
    @(posedge clk_i) mask_level_i <= 4'h0;
    for (int i = 0; i < 20 && brk_req_o; i++) @(posedge clk_i);
    acc(STATUS_OFS, 32'(e), 0);
    if (brk_req_o) begin
      num_errors++;
      final_report;
    end
    acc(CLEAR_OFS, 32'h3, 1);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    acc(8'h40, 32'h0, 0);
    acc(ENABLE_OFS, 32'h1, 1);
    go(32'h123456, 8'h6a, 5'h06, 4'h0, 4'h0, 1);
    go(32'ha80391, 8'h66, 5'h02, 4'h0, 4'h0, 0);
    go(32'h76bcdc, 8'ha7, 5'h13, 4'h0, 4'h0, 1);
    go(32'h2345c8, 8'h94, 5'h1a, 4'h0, 4'h0, 0);
    go(32'h123456, 8'h2a, 5'h06, 4'h0, 4'h0, 0);
    go(32'h406, 8'h54, 5'h0a, 4'h8, 4'h2, 1);
    go(32'h404, 8'h54, 5'h0a, 4'h3, 4'h0, 0);
    go(32'h404, 8'h54, 5'h0a, 4'h4, 4'h0, 0);
    go(32'h404, 8'h74, 5'h0a, 4'h4, 4'h0, 1);
    go(32'h30147, 8'h54, 5'h0a, 4'h0, 4'h1, 0);
    cyc_i <= {1'b1, 5'h0a, 4'h2, 32'h30147};
    @(posedge clk_i) cyc_i <= '0;
    @(posedge clk_i) aerr_done_i <= 1'b1;
    #1 chk("aerr", 32'h0, 32'(brk_req_o));
    @(posedge clk_i) aerr_done_i <= 1'b0;
    #1 chk("aerr", 32'h1, 32'(brk_req_o));
    @(posedge clk_i) acc(CLEAR_OFS, 32'h3, 1);
    // Masked break dropped by a higher exception sets the lost bit
    acc(ADDR_HIGH_OFS, 32'h12, 1);
    acc(ADDR_LOW_OFS, 32'h3456, 1);
    acc(CYCLE_SEL_OFS, 32'h6a, 1);
    mask_level_i <= 4'hf;
    cyc_i <= {1'b1, 5'h06, 4'h0, 32'h123456};
    @(posedge clk_i) cyc_i <= '0;
    hi_exc_i <= 1'b1;
    @(posedge clk_i) hi_exc_i <= 1'b0;
    #1 chk("lost", 32'h0, 32'(brk_req_o));
    @(posedge clk_i) mask_level_i <= 4'h0;
    acc(STATUS_OFS, 32'h3, 0);
    acc(CLEAR_OFS, 32'h3, 1);
    acc(STATUS_OFS, 32'h0, 0);
    repeat (24) begin
      a = $random(seed);
      mask_level_i <= {3'h7, a[4]};
      dly <= a[9:8];
      // No fetch condition on a branch destination here
      go(32'h123456, 8'h6a, 5'h06, 4'h0, a[3:0] & 4'h6, a[2:1] == 0);
    end
    final_report;
  end
endmodule
